/* File: core/adcc_regs.vh */
// Register map, field positions, reset values and timing counts
// for the converter control block.
// Assumes a 32-bit APB bus whose addresses are byte addresses.

`ifndef ADCC_REGS_VH
`define ADCC_REGS_VH

// Register byte offsets
`define ADCC_OFS_STATUS_CTRL  12'h038
`define ADCC_OFS_RESULT       12'h03C
`define ADCC_OFS_CLOCK_CTRL   12'h040

// Status/control fields
`define ADCC_SC_DONE_BIT      7
`define ADCC_SC_IRQEN_BIT     6
`define ADCC_SC_CONT_BIT      5
`define ADCC_SC_CH_HI         4
`define ADCC_SC_CH_LO         0

// Clock control fields
`define ADCC_CK_DIV_HI        7
`define ADCC_CK_DIV_LO        5
`define ADCC_CK_SEL_BIT       4

// Reset values
`define ADCC_CH_OFF           5'h1F
`define ADCC_DIV_RESET        3'h0
`define ADCC_CKSEL_RESET      1'b0

// Timing count in converter clocks, and result width in bits
`define ADCC_CONV_TICKS       5'h10
`define ADCC_RESULT_BITS      8

`endif

/* File: core/adcc_top.v */
// Converter control: registers, prescaler, SAR sequencer and pin takeover.
// Assumes an external comparator judges the selected input against the
// trial code, and that all inputs are synchronous to ref_clk.
`timescale 1ns/1ns
`include "adcc_regs.vh"

module adcc_top #(
  parameter NCH = 15
) (
  input  wire            ref_clk,
  input  wire            rst,
  input  wire            clkEn,
  // APB slave
  input  wire            psel,
  input  wire            penable,
  input  wire            pwrite,
  input  wire [11:0]     paddr,
  input  wire [31:0]     pwdata,
  output reg  [31:0]     prdata,
  output reg             pready,
  output reg             pslverr,
  // Converter clock source and comparator
  input  wire            xtalTick,
  input  wire            compareHigh,
  output reg  [7:0]      trialCode,
  output reg  [NCH-1:0]  analogSelect,
  output reg             converterOn,
  // Low-power modes
  input  wire            waitMode,
  input  wire            stopMode,
  output reg             irqReq,
  output reg             wakeReq,
  // Shared port pins
  input  wire [NCH-1:0]  portLatch,
  input  wire [NCH-1:0]  portDir,
  input  wire [NCH-1:0]  padIn,
  output reg  [NCH-1:0]  padOut,
  output reg  [NCH-1:0]  padOe_n,
  output reg  [NCH-1:0]  portReadData
);

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_CONV = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;

  reg  [4:0]  channel_r;
  reg         contMode_r;
  reg         irqEn_r;
  reg         doneFlag_r;
  reg         irqPend_r;
  reg  [2:0]  prescale_r;
  reg         clkSel_r;
  reg  [7:0]  result_r;
  reg  [7:0]  sar_r;
  reg  [2:0]  state_r;
  reg  [2:0]  state_nxt;
  reg  [4:0]  tickCnt_r;
  reg  [3:0]  divCnt_r;
  reg         convTick_r;
  reg         restart_r;
  reg  [3:0]  divMask;
  reg  [2:0]  bitIdx;

  wire        setupPh  = psel & ~penable;
  wire        accessOk = psel & penable & pready;
  wire        wrDone   = accessOk & pwrite;
  wire        rdDone   = accessOk & ~pwrite;
  wire        hitSc    = (paddr == `ADCC_OFS_STATUS_CTRL);
  wire        hitRes   = (paddr == `ADCC_OFS_RESULT);
  wire        hitCk    = (paddr == `ADCC_OFS_CLOCK_CTRL);
  wire        scWrite  = wrDone & hitSc;
  wire        resRead  = rdDone & hitRes;
  wire        chOff    = (channel_r == `ADCC_CH_OFF);
  wire        srcTick  = clkSel_r | xtalTick;
  wire        convEnd  = (state_r == ST_DONE);
  wire        lastTick = (tickCnt_r == `ADCC_CONV_TICKS - 5'h01);
  wire [4:0]  newCh    = pwdata[`ADCC_SC_CH_HI:`ADCC_SC_CH_LO];
  wire        newOff   = (newCh == `ADCC_CH_OFF);

  // ------------------------------------------------------------------
  // APB slave: no wait states, answer registered
  // ------------------------------------------------------------------
  // Read data and ready prepared in the setup cycle
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (clkEn)
    begin
      if (setupPh)
      begin
        pready  <= 1'b1;
        pslverr <= ~(hitSc | hitRes | hitCk);
        if (pwrite)
          prdata <= 32'h0000_0000;
        else if (hitSc)
          prdata <= {24'h00_0000, doneFlag_r, irqEn_r, contMode_r,
                     channel_r};
        else if (hitRes)
          prdata <= {24'h00_0000, result_r};
        else if (hitCk)
          prdata <= {24'h00_0000, prescale_r, clkSel_r, 4'h0};
        else
          prdata <= 32'h0000_0000;
      end
      else
      begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

  // Control fields written at the access edge
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      channel_r  <= `ADCC_CH_OFF;
      contMode_r <= 1'b0;
      irqEn_r    <= 1'b0;
      prescale_r <= `ADCC_DIV_RESET;
      clkSel_r   <= `ADCC_CKSEL_RESET;
    end
    else if (clkEn)
    begin
      if (scWrite)
      begin
        channel_r  <= newCh;
        contMode_r <= pwdata[`ADCC_SC_CONT_BIT];
        irqEn_r    <= pwdata[`ADCC_SC_IRQEN_BIT];
      end
      if (wrDone & hitCk)
      begin
        prescale_r <= pwdata[`ADCC_CK_DIV_HI:`ADCC_CK_DIV_LO];
        clkSel_r   <= pwdata[`ADCC_CK_SEL_BIT];
      end
    end
  end

  // ------------------------------------------------------------------
  // Converter clock prescaler
  // ------------------------------------------------------------------
  // Divide mask: 1,2,4,8, or 16 when the top bit is set
  always @*
  begin
    case (prescale_r)
      3'h0:    divMask = 4'h0;
      3'h1:    divMask = 4'h1;
      3'h2:    divMask = 4'h3;
      3'h3:    divMask = 4'h7;
      default: divMask = 4'hF;
    endcase
  end

  // Count source ticks, pulse once per converter clock
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      divCnt_r   <= 4'h0;
      convTick_r <= 1'b0;
    end
    else if (clkEn)
    begin
      convTick_r <= 1'b0;
      if (stopMode)
        divCnt_r <= 4'h0;
      else if (srcTick)
      begin
        if ((divCnt_r & divMask) == divMask)
        begin
          divCnt_r   <= 4'h0;
          convTick_r <= 1'b1;
        end
        else
          divCnt_r <= divCnt_r + 4'h1;
      end
    end
  end

  // ------------------------------------------------------------------
  // Conversion sequencer
  // ------------------------------------------------------------------
  // Next state: start on write, repeat in continuous mode
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (!stopMode && ((scWrite && !newOff) || (restart_r && !chOff)))
          state_nxt = ST_CONV;
      ST_CONV:
        if (stopMode || (scWrite && newOff))
          state_nxt = ST_IDLE;
        else if (scWrite)
          state_nxt = ST_CONV;
        else if (convTick_r && lastTick)
          state_nxt = ST_DONE;
      ST_DONE:
        if (contMode_r && !chOff && !stopMode && !scWrite)
          state_nxt = ST_CONV;
        else if (scWrite && !newOff && !stopMode)
          state_nxt = ST_CONV;
        else
          state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // Bit under trial: MSB first, two converter clocks per bit
  always @*
  begin
    bitIdx = 3'h7 - tickCnt_r[3:1];
  end

  // State, tick counter and approximation register
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_r   <= ST_IDLE;
      tickCnt_r <= 5'h00;
      sar_r     <= 8'h00;
    end
    else if (clkEn)
    begin
      state_r <= state_nxt;
      if (state_nxt == ST_CONV && (state_r != ST_CONV || scWrite))
      begin
        tickCnt_r <= 5'h00;
        sar_r     <= 8'h00;
      end
      else if (state_r == ST_CONV && convTick_r)
      begin
        tickCnt_r <= tickCnt_r + 5'h01;
        if (!tickCnt_r[0])
          sar_r[bitIdx] <= 1'b1;
        else if (!compareHigh)
          sar_r[bitIdx] <= 1'b0;
      end
    end
  end

  // Conversion aborted by stop mode is restarted from the first bit after it ends
  always @(posedge ref_clk)
  begin
    if (rst)
      restart_r <= 1'b0;
    else if (clkEn)
    begin
      if (scWrite)
        restart_r <= 1'b0;
      else if (stopMode && (state_r != ST_IDLE))
        restart_r <= 1'b1;
      else if (!stopMode && state_r == ST_CONV)
        restart_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Result, completion flag and interrupt
  // ------------------------------------------------------------------
  // Result loaded whole at the end; flags set win over clears
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      result_r   <= 8'h00;
      doneFlag_r <= 1'b0;
      irqPend_r  <= 1'b0;
    end
    else if (clkEn)
    begin
      if (convEnd)
        result_r <= sar_r;
      if (convEnd && !irqEn_r)
        doneFlag_r <= 1'b1;
      else if (scWrite || resRead || irqEn_r)
        doneFlag_r <= 1'b0;
      if (convEnd && irqEn_r)
        irqPend_r <= 1'b1;
      else if (scWrite || resRead || !irqEn_r)
        irqPend_r <= 1'b0;
    end
  end

  // Interrupt and wake outputs; wait mode does not stop conversion
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      irqReq  <= 1'b0;
      wakeReq <= 1'b0;
    end
    else if (clkEn)
    begin
      irqReq  <= irqPend_r;
      wakeReq <= irqPend_r & waitMode;
    end
  end

  // ------------------------------------------------------------------
  // Analog path outputs
  // ------------------------------------------------------------------
  // Trial code carries the bit under trial at once; power state
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      trialCode   <= 8'h00;
      converterOn <= 1'b0;
    end
    else if (clkEn)
    begin
      trialCode   <= (state_r == ST_CONV && convTick_r && !tickCnt_r[0])
                     ? (sar_r | (8'h80 >> tickCnt_r[3:1])) : sar_r;
      converterOn <= ~chOff & ~stopMode;
    end
  end

  // ------------------------------------------------------------------
  // Per-channel pin takeover
  // ------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi = gi + 1)
    begin : gPin
      localparam [4:0] CH_CODE = gi;
      wire taken = (channel_r == CH_CODE);

      // Selected pin becomes analog input; others stay port pins
      always @(posedge ref_clk)
      begin
        if (rst)
        begin
          analogSelect[gi] <= 1'b0;
          padOut[gi]       <= 1'b0;
          padOe_n[gi]      <= 1'b1;
          portReadData[gi] <= 1'b0;
        end
        else if (clkEn)
        begin
          analogSelect[gi] <= taken;
          padOut[gi]       <= portLatch[gi];
          if (taken)
          begin
            padOe_n[gi]      <= 1'b1;
            portReadData[gi] <= portDir[gi] & portLatch[gi];
          end
          else
          begin
            padOe_n[gi]      <= ~portDir[gi];
            portReadData[gi] <= portDir[gi] ? portLatch[gi] : padIn[gi];
          end
        end
      end
    end
  endgenerate

endmodule // adcc_top

/* File: verification/adcc_far_model.sv */
// Far side: analog sources on the shared pins and the comparator.
// Assumes a one-hot channel select and an 8-bit trial code.
`timescale 1ns/1ns
module adcc_far_model #(
  parameter NCH = 15
) (
  input  wire            ref_clk,
  input  wire [NCH-1:0]  analogSelect,
  input  wire [7:0]      trialCode,
  input  wire [7:0]      ofs,
  output wire            compareHigh
);
  logic [7:0] vin;
  logic       flip = 1'b0;
  // Channel k sits at k*11h plus offset
  always_comb
  begin
    vin = 8'h00;
    for (int k = 0; k < NCH; k++)
      if (analogSelect[k])
        vin = k[7:0] * 8'h11 + ofs;
  end
  // Unrouted comparator wanders
  always @(posedge ref_clk) flip <= ~flip;
  assign compareHigh = |analogSelect ? vin >= trialCode : flip;
endmodule // adcc_far_model

/* File: verification/adcc_chk_monitor.sv */
// Port assertions for the converter control block.
// Bound into adcc_top; assumes clkEn held high.
`timescale 1ns/1ns
`include "adcc_regs.vh"
module adcc_chk_monitor #(
  parameter NCH = 15
) (
  input wire            ref_clk,
  input wire            rst,
  input wire            psel,
  input wire            penable,
  input wire            pwrite,
  input wire [11:0]     paddr,
  input wire [31:0]     prdata,
  input wire            pready,
  input wire            pslverr,
  input wire [NCH-1:0]  analogSelect,
  input wire            converterOn,
  input wire            waitMode,
  input wire            stopMode,
  input wire            irqReq,
  input wire            wakeReq,
  input wire [NCH-1:0]  portLatch,
  input wire [NCH-1:0]  portDir,
  input wire [NCH-1:0]  padOut,
  input wire [NCH-1:0]  padOe_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Accepted accesses that clear a pending interrupt
  wire acc = psel && penable && pready;
  wire clrIrq = acc && (pwrite ? paddr == `ADCC_OFS_STATUS_CTRL
                               : paddr == `ADCC_OFS_RESULT);

  one_hot_a: assert property ($onehot0(analogSelect))
    else $error("several inputs routed");
  pin_takeover_a: assert property ((analogSelect & ~padOe_n) == '0)
    else $error("routed pin still driven");
  gpio_dir_a: assert property (!$past(rst) && converterOn |->
    ((padOe_n ^ ~$past(portDir)) & ~analogSelect) == '0)
    else $error("free pin direction wrong");
  port_out_a: assert property (!$past(rst) |-> padOut == $past(portLatch))
    else $error("pin output not latch");
  stop_idle_a: assert property (stopMode |=> !converterOn)
    else $error("converter on in stop");
  irq_clear_a: assert property (clrIrq |-> ##[1:2] !irqReq)
    else $error("interrupt not cleared");
  wake_on_a: assert property (irqReq && waitMode ##1 irqReq && waitMode
    |-> wakeReq)
    else $error("no wake request");
  wake_off_a: assert property (!waitMode ##1 !waitMode |-> !wakeReq)
    else $error("wake outside wait");
  data_width_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");

  cover property (irqReq && waitMode);
  cover property (stopMode && converterOn);
  cover property (acc && pslverr);
endmodule // adcc_chk_monitor

bind adcc_top adcc_chk_monitor #(.NCH(NCH)) u_adcc_chk_monitor (.*);

/* File: verification/adcc_testbench.sv */
// Register-level tests of the converter control block.
// Assumes the far model stands in for pins and comparator.
`timescale 1ns/1ns
`include "adcc_regs.vh"
module testbench;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        clkEn = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        xtalTick = 1'b0;
  logic        waitMode = 1'b0;
  logic        stopMode = 1'b0;
  logic [14:0] portLatch = 15'h0000;
  logic [14:0] portDir = 15'h0000;
  logic [14:0] padIn = 15'h0000;
  logic [7:0]  ofs = 8'h00;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, compareHigh, converterOn, irqReq, wakeReq;
  logic [7:0]  trialCode;
  logic [14:0] analogSelect, padOut, padOe_n, portReadData;
  logic [2:0]  dv;
  int          n_fail = 0;
  int          n_compared = 0;
  int          n;
  localparam logic [11:0] SC = `ADCC_OFS_STATUS_CTRL;
  localparam logic [11:0] RS = `ADCC_OFS_RESULT;
  localparam logic [11:0] CK = `ADCC_OFS_CLOCK_CTRL;

  adcc_top u_adcc_top (.*);
  adcc_far_model u_adcc_far_model (.*);

  initial forever #5 ref_clk = ~ref_clk;
  // Crystal tick every other cycle
  always @(posedge ref_clk) xtalTick <= ~xtalTick;

  function logic [7:0] lvl(input logic [4:0] ch);
    lvl = ch * 8'h11 + ofs;
  endfunction

  task chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      n_fail++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task waitIrq;
    n = 0;
    while (irqReq !== 1'b1 && n < 600)
    begin
      @(posedge ref_clk);
      n++;
    end
  endtask

  // Interrupt-driven single conversion: time and result
  task conv(input logic [4:0] ch, input int d);
    apb(1'b1, SC, {24'h0, 3'b010, ch});
    waitIrq;
    chk(n >= 15 * d && n <= 17 * d + 6, 1);
    apb(1'b0, RS, 32'h0);
    chk(rd, {24'h0, lvl(ch)});
  endtask

  task end_sim;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    end_sim;
  end

  initial
  begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    apb(1'b0, SC, 32'h0);
    chk(rd, 32'h1F);
    apb(1'b0, 12'h044, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, CK, 32'h10);
    // Timer clock inputs unused here, so every channel may be converted
    for (int c = 0; c < 15; c++)
      conv(c[4:0], 1);
    for (int i = 0; i < 6; i++)
    begin
      dv = (i == 5) ? 3'h7 : i[2:0];
      apb(1'b1, CK, {24'h0, dv, 5'h10});
      conv(5'h03, dv[2] ? 16 : 1 << dv);
    end
    apb(1'b1, CK, 32'h0);
    conv(5'h07, 2);
    // Pin takeover on channel seven
    portLatch <= 15'h00FF;
    portDir <= 15'h7FFF;
    repeat (3) @(posedge ref_clk);
    chk(padOe_n, 15'h0080);
    chk(portReadData[7], 1'b1);
    chk(analogSelect, 15'h0080);
    chk(trialCode, {24'h0, lvl(5'h07)});
    chk(padOut, 15'h00FF);
    portDir <= 15'h7F7E;
    padIn <= 15'h0081;
    repeat (3) @(posedge ref_clk);
    chk({portReadData[7], padOe_n}, 16'h0081);
    chk(portReadData, 15'h007F);
    // Continuous with interrupt during wait
    apb(1'b1, CK, 32'h10);
    waitMode <= 1'b1;
    apb(1'b1, SC, 32'h65);
    waitIrq;
    repeat (2) @(posedge ref_clk);
    chk(wakeReq, 1'b1);
    apb(1'b0, SC, 32'h0);
    chk(rd, 32'h65);
    ofs <= 8'h07;
    repeat (60) @(posedge ref_clk);
    apb(1'b1, SC, 32'h65);
    @(posedge ref_clk);
    waitIrq;
    apb(1'b0, RS, 32'h0);
    chk(rd, {24'h0, lvl(5'h05)});
    repeat (2) @(posedge ref_clk);
    waitIrq;
    chk(n < 25, 1);
    // Stop aborts, then restarts
    waitMode <= 1'b0;
    apb(1'b1, SC, 32'h42);
    stopMode <= 1'b1;
    repeat (40) @(posedge ref_clk);
    chk(irqReq, 1'b0);
    stopMode <= 1'b0;
    waitIrq;
    chk(n < 25, 1);
    // Done flag without interrupts
    apb(1'b1, SC, 32'h21);
    repeat (60) @(posedge ref_clk);
    apb(1'b0, SC, 32'h0);
    chk(rd, 32'hA1);
    apb(1'b1, SC, 32'h01);
    repeat (40) @(posedge ref_clk);
    apb(1'b0, SC, 32'h0);
    chk(rd, 32'h81);
    apb(1'b0, RS, 32'h0);
    apb(1'b0, SC, 32'h0);
    chk(rd, 32'h01);
    repeat (60) @(posedge ref_clk);
    apb(1'b0, SC, 32'h0);
    chk(rd, 32'h01);
    // Unused channel code: conversion runs with no pin routed
    apb(1'b1, SC, 32'h4F);
    waitIrq;
    chk(analogSelect, 15'h0000);
    chk(n < 25, 1);
    // Converter powered down before wait, so nothing wakes
    apb(1'b1, SC, 32'h1F);
    waitMode <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk(converterOn, 1'b0);
    repeat (40) @(posedge ref_clk);
    chk(wakeReq, 1'b0);
    chk(irqReq, 1'b0);
    end_sim;
  end
endmodule // testbench
